// file: common/rsq_pkg.sv
`default_nettype none
package rsq_pkg;

  // widths
  localparam int CNT_W   = 13;
  localparam int PRE_W   = 13;
  localparam int WD_W    = 8;
  localparam int IRQ_N   = 8;
  localparam int SEL_W   = 3;
  localparam int FLAG_W  = 7;
  localparam int ADDR_W  = 5;
  localparam int ASYNC_W = 7;

  // sequencer timing, in oscillator cycles
  localparam int POR_CYC         = 4096;
  localparam int DRIVE_CYC       = 32;
  localparam int HOLD_CYC        = 32;
  localparam int PIN_MIN_CYC     = 67;
  localparam int PIN_POR_CYC_DEF = 4163;
  localparam logic [CNT_W-1:0] POR_LAST     = CNT_W'(POR_CYC - 1);
  localparam logic [CNT_W-1:0] DRIVE_LAST   = CNT_W'(DRIVE_CYC - 1);
  localparam logic [CNT_W-1:0] HOLD_LAST    = CNT_W'(HOLD_CYC - 1);
  localparam logic [CNT_W-1:0] PIN_MIN_LAST = CNT_W'(PIN_MIN_CYC - 1);

  // prescaler bits kept by a watchdog service write
  localparam int PRE_SVC_LO = 4;

  // reset vectors and erased byte
  localparam logic [15:0] VEC_USER   = 16'hFFFE;
  localparam logic [15:0] VEC_MON    = 16'hFEFE;
  localparam logic [7:0]  BLANK_BYTE = 8'hFF;

  // opcode fetch map
  localparam logic [15:0] FLASH_LO = 16'h8000;
  localparam logic [15:0] FLASH_HI = 16'hFFFF;
  localparam logic [15:0] RAM_LO   = 16'h0040;
  localparam logic [15:0] RAM_HI   = 16'h07FF;

  // cause flag positions
  localparam int FLAG_POR   = 0;
  localparam int FLAG_PIN   = 1;
  localparam int FLAG_WDOG  = 2;
  localparam int FLAG_OP    = 3;
  localparam int FLAG_ADDR  = 4;
  localparam int FLAG_BLANK = 5;
  localparam int FLAG_BROWN = 6;
  localparam logic [FLAG_W-1:0] FLAGS_RST = 7'h01;

  // asynchronous input positions and idle level
  localparam int A_PU  = 0;
  localparam int A_BO  = 1;
  localparam int A_PIN = 2;
  localparam int A_HVR = 3;
  localparam int A_HVI = 4;
  localparam int A_MON = 5;
  localparam int A_BRK = 6;
  localparam logic [ASYNC_W-1:0] SYNC_IDLE = 7'h04;

  // register offsets and responses
  localparam logic [ADDR_W-1:0] OFF_CAUSE   = 5'h00;
  localparam logic [ADDR_W-1:0] OFF_SERVICE = 5'h04;
  localparam logic [ADDR_W-1:0] OFF_STATUS  = 5'h08;
  localparam logic [ADDR_W-1:0] OFF_INT     = 5'h0C;
  localparam logic [1:0]        RESP_OKAY   = 2'h0;
  localparam logic [1:0]        RESP_SLVERR = 2'h2;

  // sequencer states, gray along por, drive, hold, run, ext
  typedef enum logic [2:0] {
    ST_POR   = 3'h0,
    ST_DRIVE = 3'h1,
    ST_HOLD  = 3'h3,
    ST_RUN   = 3'h2,
    ST_EXT   = 3'h6
  } rsq_state_t;

endpackage
`default_nettype wire

// file: logic/rsq_reset_seq.sv
// Register access over AXI4-Lite and the register addresses were decided locally.
`timescale 1ns/1ns
`default_nettype none
module rsq_reset_seq
  import rsq_pkg::*;
#(
  parameter int PIN_POR_CYC = PIN_POR_CYC_DEF
)
(
  // clock and reset
  input  wire logic              CLK_I,
  input  wire logic              RST_N_I,
  // asynchronous sources and pins
  input  wire logic              POWER_UP_I,
  input  wire logic              BROWNOUT_I,
  input  wire logic              RST_PIN_I,
  input  wire logic              HV_RST_I,
  input  wire logic              HV_IRQ_I,
  input  wire logic              MONITOR_I,
  input  wire logic              BREAK_I,
  output logic                   RST_PIN_O,
  output logic                   RST_PIN_OE_N_O,
  // cpu decode signals
  input  wire logic              BAD_OPCODE_I,
  input  wire logic              STOP_EXEC_I,
  input  wire logic              OPFETCH_I,
  input  wire logic [15:0]       FETCH_ADDR_I,
  input  wire logic              VEC_FETCH_I,
  input  wire logic [7:0]        VEC_DATA_I,
  // interrupt arbitration
  input  wire logic [IRQ_N-1:0]  IRQ_REQ_I,
  input  wire logic              IMASK_I,
  input  wire logic              INT_START_I,
  input  wire logic              INT_DONE_I,
  output logic                   INT_VALID_O,
  output logic [SEL_W-1:0]       INT_SEL_O,
  // system outputs
  output logic                   INT_RST_O,
  output logic                   BUS_CLK_EN_O,
  output logic                   BUS_CLK_O,
  output logic [15:0]            VECTOR_O,
  output logic                   FORCE_MON_O,
  // axi4-lite write
  input  wire logic              S_AXI_AWVALID_I,
  output logic                   S_AXI_AWREADY_O,
  input  wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
  input  wire logic              S_AXI_WVALID_I,
  output logic                   S_AXI_WREADY_O,
  input  wire logic [31:0]       S_AXI_WDATA_I,
  input  wire logic [3:0]        S_AXI_WSTRB_I,
  output logic                   S_AXI_BVALID_O,
  input  wire logic              S_AXI_BREADY_I,
  output logic [1:0]             S_AXI_BRESP_O,
  // axi4-lite read
  input  wire logic              S_AXI_ARVALID_I,
  output logic                   S_AXI_ARREADY_O,
  input  wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
  output logic                   S_AXI_RVALID_O,
  input  wire logic              S_AXI_RREADY_I,
  output logic [31:0]            S_AXI_RDATA_O,
  output logic [1:0]             S_AXI_RRESP_O
);

  localparam logic [CNT_W-1:0] PIN_POR_LAST = CNT_W'(PIN_POR_CYC - 1);

  typedef struct packed {
    logic [ASYNC_W-1:0] s1;
    logic [ASYNC_W-1:0] s2;
    rsq_state_t         st;
    logic [CNT_W-1:0]   cnt;
    logic               por_seq;
    logic [PRE_W-1:0]   pre;
    logic [WD_W-1:0]    wd;
    logic               wd_trip;
    logic [CNT_W-1:0]   pin_cnt;
    logic               pin_por;
    logic [FLAG_W-1:0]  flags;
    logic               force_mon;
    logic               internal_reset_line;
    logic               pin_oe_n;
    logic               pin_lvl;
    logic               clk_en;
    logic               bus_clk;
    logic [15:0]        vec;
    logic               imask_d;
    logic               int_valid;
    logic [SEL_W-1:0]   int_sel;
    logic               awready;
    logic               wready;
    logic               aw_have;
    logic               w_have;
    logic [ADDR_W-1:0]  awaddr;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               arready;
    logic               rvalid;
    logic [31:0]        rdata;
    logic [1:0]         rresp;
  } rsq_regs_t;

  localparam rsq_regs_t REGS_RST = '{
    s1: SYNC_IDLE, s2: SYNC_IDLE, st: ST_POR, cnt: '0, por_seq: 1'b1,
    pre: '0, wd: '0, wd_trip: 1'b0, pin_cnt: '0, pin_por: 1'b1,
    flags: FLAGS_RST, force_mon: 1'b0, internal_reset_line: 1'b1, pin_oe_n: 1'b0,
    pin_lvl: 1'b0, clk_en: 1'b0, bus_clk: 1'b0, vec: VEC_USER,
    imask_d: 1'b1, int_valid: 1'b0, int_sel: '0, awready: 1'b1,
    wready: 1'b1, aw_have: 1'b0, w_have: 1'b0, awaddr: '0, bvalid: 1'b0,
    bresp: RESP_OKAY, arready: 1'b1, rvalid: 1'b0, rdata: '0,
    rresp: RESP_OKAY
  };

  rsq_regs_t          r_reg;
  rsq_regs_t          r_next;
  logic [ASYNC_W-1:0] async_in;
  logic               pin_low;
  logic               wd_dis;
  logic               ev_pu;
  logic               ev_bo;
  logic               ev_op;
  logic               ev_ad;
  logic               ev_bv;
  logic               ev_wd;
  logic               ev_int;
  logic               pin_set;
  logic               rel_int;
  logic               ar_hs;
  logic               rd_cause;
  logic               wr_go;
  logic               svc;
  logic [31:0]        rd_word;

  // opcode fetch lands in flash or ram
  function automatic logic in_map(input logic [15:0] a);
    in_map = ((a >= FLASH_LO) && (a <= FLASH_HI)) || ((a >= RAM_LO) && (a <= RAM_HI));
  endfunction

  // register offset decode
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
    reg_hit = (a == OFF_CAUSE) || (a == OFF_SERVICE) || (a == OFF_STATUS) || (a == OFF_INT);
  endfunction

  // lowest index request wins
  function automatic logic [SEL_W-1:0] prio(input logic [IRQ_N-1:0] req);
    prio = '0;
    for (int i = IRQ_N - 1; i >= 0; i--)
    begin
      if (req[i])
        prio = SEL_W'(i);
    end
  endfunction

  // asynchronous inputs gathered for the synchroniser
  assign async_in = {BREAK_I, MONITOR_I, HV_IRQ_I, HV_RST_I, RST_PIN_I, BROWNOUT_I, POWER_UP_I};

  assign pin_low = !r_reg.s2[A_PIN];
  assign ev_pu   = r_reg.s2[A_PU];
  assign ev_bo   = r_reg.s2[A_BO];

  assign wd_dis = (r_reg.s2[A_MON] && (r_reg.s2[A_HVR] || r_reg.s2[A_HVI]))
               || (r_reg.s2[A_BRK] && r_reg.s2[A_HVR]);

  assign ev_op = !r_reg.internal_reset_line && (BAD_OPCODE_I || STOP_EXEC_I);
  assign ev_ad = !r_reg.internal_reset_line && OPFETCH_I && !in_map(FETCH_ADDR_I);
  assign ev_bv = !r_reg.internal_reset_line && VEC_FETCH_I && (VEC_DATA_I == BLANK_BYTE);
  assign ev_wd  = r_reg.wd_trip;
  assign ev_int = ev_op || ev_ad || ev_bv || ev_wd;

  assign pin_set = pin_low
                && (r_reg.pin_cnt == (r_reg.pin_por ? PIN_POR_LAST : PIN_MIN_LAST));

  // release on service, mask clear or internal reset
  assign rel_int = INT_DONE_I || (r_reg.imask_d && !IMASK_I) || r_reg.internal_reset_line;

  // bus handshakes
  assign ar_hs    = S_AXI_ARVALID_I && r_reg.arready;
  assign rd_cause = ar_hs && (S_AXI_ARADDR_I == OFF_CAUSE);
  assign wr_go    = r_reg.aw_have && r_reg.w_have && !r_reg.bvalid;
  assign svc      = wr_go && (r_reg.awaddr == OFF_SERVICE);

  // read data mux
  always_comb
  begin
    case (S_AXI_ARADDR_I)
      OFF_CAUSE:  rd_word = {25'h000_0000, r_reg.flags};
      OFF_STATUS: rd_word = {3'h0, r_reg.pre, r_reg.wd, 2'h0, r_reg.force_mon,
                             r_reg.clk_en, r_reg.internal_reset_line, r_reg.st};
      OFF_INT:    rd_word = {23'h00_0000, r_reg.int_valid, 5'h00, r_reg.int_sel};
      default:    rd_word = 32'h0000_0000;
    endcase
  end

  // next state of the whole block
  always_comb
  begin
    r_next    = r_reg;
    r_next.s1 = async_in;
    r_next.s2 = r_reg.s1;
    r_next.imask_d = IMASK_I;

    r_next.pre     = r_reg.pre + 13'h0001;
    r_next.wd_trip = 1'b0;
    if (r_reg.internal_reset_line || wd_dis)
      r_next.wd = '0;
    else if (&r_reg.pre)
    begin
      r_next.wd = r_reg.wd + 8'h01;
      if (&r_reg.wd)
        r_next.wd_trip = 1'b1;
    end
    if (svc)
    begin
      r_next.wd  = '0;
      r_next.pre = {(PRE_W - PRE_SVC_LO)'(0), r_reg.pre[PRE_SVC_LO-1:0]};
    end

    // sequencer
    r_next.cnt = r_reg.cnt + 13'h0001;
    case (r_reg.st)
      ST_POR:
      begin
        if (r_reg.cnt == POR_LAST)
        begin
          r_next.st  = ST_DRIVE;
          r_next.cnt = '0;
        end
      end
      ST_DRIVE:
      begin
        if (r_reg.cnt == DRIVE_LAST)
        begin
          r_next.st  = ST_HOLD;
          r_next.cnt = '0;
        end
      end
      ST_HOLD:
      begin
        if (r_reg.cnt == HOLD_LAST)
        begin
          r_next.st      = ST_RUN;
          r_next.cnt     = '0;
          r_next.por_seq = 1'b0;
        end
      end
      ST_RUN:
      begin
        r_next.cnt = '0;
        if (pin_low)
          r_next.st = ST_EXT;
      end
      ST_EXT:
      begin
        r_next.cnt = '0;
        if (!pin_low)
          r_next.st = ST_HOLD;
      end
      default:
      begin
        r_next.st  = ST_POR;
        r_next.cnt = '0;
      end
    endcase

    if (ev_int)
    begin
      r_next.st  = ST_DRIVE;
      r_next.cnt = '0;
      r_next.pre = '0;
    end
    if (ev_pu || ev_bo)
    begin
      r_next.st      = ST_POR;
      r_next.cnt     = '0;
      r_next.pre     = '0;
      r_next.por_seq = 1'b1;
    end

    r_next.clk_en  = (r_next.st != ST_POR);
    r_next.bus_clk = r_next.clk_en ? !r_reg.bus_clk : 1'b0;
    r_next.pin_oe_n = !((r_next.st == ST_POR) || (r_next.st == ST_DRIVE));
    r_next.pin_lvl  = 1'b0;
    r_next.internal_reset_line = (r_next.st != ST_RUN);

    if (ev_bv)
      r_next.force_mon = 1'b1;
    if (ev_pu)
      r_next.force_mon = 1'b0;
    r_next.vec = (r_reg.s2[A_MON] || r_reg.force_mon) ? VEC_MON : VEC_USER;

    if (pin_low)
    begin
      if (r_reg.pin_cnt != '1)
        r_next.pin_cnt = r_reg.pin_cnt + 13'h0001;
      if (r_reg.pin_cnt == '0)
        r_next.pin_por = r_reg.por_seq;
    end
    else
      r_next.pin_cnt = '0;

    if (rd_cause)
      r_next.flags = '0;
    if (pin_set)
      r_next.flags[FLAG_PIN] = 1'b1;
    if (ev_wd)
      r_next.flags[FLAG_WDOG] = 1'b1;
    if (ev_op)
      r_next.flags[FLAG_OP] = 1'b1;
    if (ev_ad)
      r_next.flags[FLAG_ADDR] = 1'b1;
    if (ev_bv)
      r_next.flags[FLAG_BLANK] = 1'b1;
    if (ev_bo)
      r_next.flags[FLAG_BROWN] = 1'b1;
    if (ev_pu)
      r_next.flags = FLAGS_RST;

    if (r_reg.int_valid)
    begin
      if (rel_int)
        r_next.int_valid = 1'b0;
    end
    else if (INT_START_I && (|IRQ_REQ_I) && !r_reg.internal_reset_line)
    begin
      r_next.int_valid = 1'b1;
      r_next.int_sel   = prio(IRQ_REQ_I);
    end

    // write address and data, either order
    if (S_AXI_AWVALID_I && r_reg.awready)
    begin
      r_next.aw_have = 1'b1;
      r_next.awaddr  = S_AXI_AWADDR_I;
      r_next.awready = 1'b0;
    end
    if (S_AXI_WVALID_I && r_reg.wready)
    begin
      r_next.w_have = 1'b1;
      r_next.wready = 1'b0;
    end
    if (wr_go)
    begin
      r_next.bvalid  = 1'b1;
      r_next.bresp   = reg_hit(r_reg.awaddr) ? RESP_OKAY : RESP_SLVERR;
      r_next.aw_have = 1'b0;
      r_next.w_have  = 1'b0;
    end
    if (r_reg.bvalid && S_AXI_BREADY_I)
    begin
      r_next.bvalid  = 1'b0;
      r_next.awready = 1'b1;
      r_next.wready  = 1'b1;
    end

    // read channel
    if (ar_hs)
    begin
      r_next.arready = 1'b0;
      r_next.rvalid  = 1'b1;
      r_next.rdata   = rd_word;
      r_next.rresp   = reg_hit(S_AXI_ARADDR_I) ? RESP_OKAY : RESP_SLVERR;
    end
    if (r_reg.rvalid && S_AXI_RREADY_I)
    begin
      r_next.rvalid  = 1'b0;
      r_next.arready = 1'b1;
    end
  end

  // state register
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
      r_reg <= REGS_RST;
    else
      r_reg <= r_next;
  end

  // outputs straight from flops
  assign RST_PIN_O       = r_reg.pin_lvl;
  assign RST_PIN_OE_N_O  = r_reg.pin_oe_n;
  assign INT_VALID_O     = r_reg.int_valid;
  assign INT_SEL_O       = r_reg.int_sel;
  assign INT_RST_O       = r_reg.internal_reset_line;
  assign BUS_CLK_EN_O    = r_reg.clk_en;
  assign BUS_CLK_O       = r_reg.bus_clk;
  assign VECTOR_O        = r_reg.vec;
  assign FORCE_MON_O     = r_reg.force_mon;
  assign S_AXI_AWREADY_O = r_reg.awready;
  assign S_AXI_WREADY_O  = r_reg.wready;
  assign S_AXI_BVALID_O  = r_reg.bvalid;
  assign S_AXI_BRESP_O   = r_reg.bresp;
  assign S_AXI_ARREADY_O = r_reg.arready;
  assign S_AXI_RVALID_O  = r_reg.rvalid;
  assign S_AXI_RDATA_O   = r_reg.rdata;
  assign S_AXI_RRESP_O   = r_reg.rresp;

  // cycles since the state was entered or restarted, checking only
  logic [CNT_W-1:0] stay_reg;
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I || (r_next.st != r_reg.st) || ev_pu || ev_bo || ev_int)
      stay_reg <= '0;
    else if (stay_reg != '1)
      stay_reg <= stay_reg + 13'h0001;
  end

  default clocking dcb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_N_I);

  sequence left_drive_s;
    (r_reg.st == ST_HOLD) && ($past(r_reg.st) == ST_DRIVE);
  endsequence
  sequence left_hold_s;
    (r_reg.st == ST_RUN) && ($past(r_reg.st) == ST_HOLD);
  endsequence
  sequence left_por_s;
    (r_reg.st == ST_DRIVE) && ($past(r_reg.st) == ST_POR);
  endsequence

  por_clk_stop_a: assert property ((r_reg.st == ST_POR) |-> (!BUS_CLK_EN_O && !BUS_CLK_O && INT_RST_O))
    else $error("bus clock running during power-up hold");
  por_pin_low_a: assert property ((r_reg.st == ST_POR) |-> !RST_PIN_OE_N_O)
    else $error("reset pin released during power-up hold");
  drive_len_a: assert property (left_drive_s |-> ($past(stay_reg) == DRIVE_LAST))
    else $error("pin drive phase length wrong");
  hold_len_a: assert property (left_hold_s |-> ($past(stay_reg) == HOLD_LAST && !INT_RST_O))
    else $error("internal reset hold length wrong");
  por_len_a: assert property (left_por_s |-> ($past(stay_reg) == POR_LAST || $past(ev_int)))
    else $error("power-up count length wrong");
  por_flags_a: assert property (ev_pu |=> (r_reg.flags == FLAGS_RST))
    else $error("power-up flags not exclusive");
  pin_flag_a: assert property ($rose(r_reg.flags[FLAG_PIN]) |-> ($past(r_reg.pin_cnt) >= PIN_MIN_LAST))
    else $error("pin flag set too early");
  service_clr_a: assert property (svc |=> (r_reg.wd == '0) && (r_reg.pre[PRE_W-1:PRE_SVC_LO] == '0))
    else $error("service write did not clear counters");
  bad_op_a: assert property ((ev_op && !ev_pu && !ev_bo) |=> (r_reg.st == ST_DRIVE) ##0 r_reg.flags[FLAG_OP] ##1 !RST_PIN_OE_N_O)
    else $error("illegal opcode reset not taken");
  cause_read_a: assert property (rd_cause |=> (S_AXI_RDATA_O == {25'h000_0000, $past(r_reg.flags)}))
    else $error("cause read returned wrong data");
  int_hold_a: assert property ((r_reg.int_valid && !rel_int) |=> (r_reg.int_valid && $stable(r_reg.int_sel)))
    else $error("latched interrupt displaced");

endmodule
`default_nettype wire

// file: test/rsq_pin_model.sv
`timescale 1ns/1ns
`default_nettype none
module rsq_pin_model
(
  // device side and outside world
  input  wire logic dev_oe_n_i,
  input  wire logic ext_low_i,
  output logic      pin_o
);
  // pull-up unless a party drives low
  // outside party holds pin
  assign pin_o = dev_oe_n_i & ~ext_low_i;
endmodule
`default_nettype wire

// file: test/reset_sequencer_with_prescaler_bench.sv
`timescale 1ns/1ns
`default_nettype none
module reset_sequencer_with_prescaler_bench;
  import rsq_pkg::*;
  logic        clk, rst_n, pu, bo, ext_low, pin, oe_n, pin_drv, hvr, hvi, mon, brk;
  logic        bad_op, stop, opf, vf, imask, istart, idone, ivalid, int_rst, clk_en, bclk;
  logic        fmon, b0, awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
  logic [15:0] faddr, vec;
  logic [7:0]  vdata, irq;
  logic [2:0]  isel;
  logic [4:0]  awa, ara;
  logic [31:0] wd, rd, rd_mask;
  logic [1:0]  bresp, rresp;
  int          n_mismatch, n_checks;

  rsq_pin_model pm (.dev_oe_n_i(oe_n), .ext_low_i(ext_low), .pin_o(pin));

  rsq_reset_seq dut (
    .CLK_I(clk), .RST_N_I(rst_n), .POWER_UP_I(pu), .BROWNOUT_I(bo), .RST_PIN_I(pin),
    .HV_RST_I(hvr), .HV_IRQ_I(hvi), .MONITOR_I(mon), .BREAK_I(brk), .RST_PIN_O(pin_drv),
    .RST_PIN_OE_N_O(oe_n), .BAD_OPCODE_I(bad_op), .STOP_EXEC_I(stop), .OPFETCH_I(opf),
    .FETCH_ADDR_I(faddr), .VEC_FETCH_I(vf), .VEC_DATA_I(vdata), .IRQ_REQ_I(irq),
    .IMASK_I(imask), .INT_START_I(istart), .INT_DONE_I(idone), .INT_VALID_O(ivalid),
    .INT_SEL_O(isel), .INT_RST_O(int_rst), .BUS_CLK_EN_O(clk_en), .BUS_CLK_O(bclk),
    .VECTOR_O(vec), .FORCE_MON_O(fmon), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr),
    .S_AXI_AWADDR_I(awa), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wr), .S_AXI_WDATA_I(wd),
    .S_AXI_WSTRB_I(4'hF), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(br), .S_AXI_BRESP_O(bresp),
    .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr), .S_AXI_ARADDR_I(ara),
    .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rr), .S_AXI_RDATA_O(rd), .S_AXI_RRESP_O(rresp)
  );

  // clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task give_verdict;
    begin
      if (n_mismatch == 0 && n_checks > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      n_checks++;
      if (got !== exp)
      begin
        n_mismatch++;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // write: both channels offered, each dropped when taken
  task wr_reg(input logic [4:0] a);
    int n;
    begin
      n = 0;
      awv <= 1'b1;
      wv <= 1'b1;
      awa <= a;
      wd <= 32'h0000_00A5;
      br <= 1'b1;
      do
      begin
        @(posedge clk);
        if (awv && awr) awv <= 1'b0;
        if (wv && wr) wv <= 1'b0;
        n++;
      end while (!bv && n < 50);
      br <= 1'b0;
      chk(32'(bresp), 32'(RESP_OKAY));
    end
  endtask

  // read and compare data and response
  task rd_chk(input logic [4:0] a, input logic [31:0] exp, input logic [1:0] resp);
    int n;
    begin
      n = 0;
      arv <= 1'b1;
      ara <= a;
      rr <= 1'b1;
      do
      begin
        @(posedge clk);
        if (arv && arr) arv <= 1'b0;
        n++;
      end while (!rv && n < 50);
      chk(rd & rd_mask, exp);
      chk(32'(rresp), 32'(resp));
    end
  endtask

  // internal event (or in-map fetch, no reset), then drive, hold and run phases
  task ev(input int k, input logic [31:0] exp);
    begin
      case (k)
        0: bad_op <= 1'b1;
        1: stop <= 1'b1;
        2: faddr <= 16'h4000;
        3: faddr <= 16'h8000;
        default: vf <= 1'b1;
      endcase
      opf <= (k == 2 || k == 3);
      @(posedge clk);
      if (k == 4) @(posedge clk);
      bad_op <= 1'b0;
      stop <= 1'b0;
      opf <= 1'b0;
      vf <= 1'b0;
      cyc(10);
      chk(32'(oe_n), 32'(exp == 0));
      cyc(30);
      chk(32'(oe_n), 1);
      chk(32'(int_rst), 32'(exp != 0));
      cyc(30);
      chk(32'(int_rst), 0);
      rd_chk(OFF_CAUSE, exp, RESP_OKAY);
    end
  endtask

  // hang guard
  initial
  begin
    cyc(30000);
    n_mismatch++;
    give_verdict();
  end

  // main sequence
  initial
  begin
    {pu, bo, ext_low, hvr, hvi, mon, brk, bad_op, stop, opf, vf} = '0;
    {imask, istart, idone, awv, wv, br, arv, rr} = '0;
    {faddr, irq, awa, ara, wd} = '0;
    vdata = 8'hFF;
    rd_mask = 32'hFFFF_FFFF;
    rst_n = 1'b0;
    n_mismatch = 0;
    n_checks = 0;
    cyc(12);
    rst_n <= 1'b1;
    cyc(4000);
    chk({oe_n, clk_en, int_rst}, 32'h1);
    chk(32'(pin_drv), 0);
    cyc(136);
    chk({oe_n, clk_en, int_rst}, 32'h7);
    cyc(30);
    chk(32'(int_rst), 0);
    b0 = bclk;
    @(posedge clk);
    chk(32'(bclk ^ b0), 1);
    rd_chk(OFF_CAUSE, 32'h1, RESP_OKAY);
    rd_chk(OFF_CAUSE, 32'h0, RESP_OKAY);
    rd_chk(5'h10, 32'h0, RESP_SLVERR);
    wr_reg(OFF_SERVICE);
    // prescaler low bits keep running after service
    rd_mask = 32'hFFF0_FFFF;
    rd_chk(OFF_STATUS, 32'h0000_0012, RESP_OKAY);
    rd_mask = 32'hFFFF_FFFF;
    // pin reset long enough, then too short
    ext_low <= 1'b1;
    cyc(80);
    chk(32'(int_rst), 1);
    ext_low <= 1'b0;
    cyc(60);
    rd_chk(OFF_CAUSE, 32'h2, RESP_OKAY);
    ext_low <= 1'b1;
    cyc(30);
    ext_low <= 1'b0;
    cyc(60);
    rd_chk(OFF_CAUSE, 32'h0, RESP_OKAY);
    // brown-out runs the long sequence
    bo <= 1'b1;
    cyc(5);
    bo <= 1'b0;
    cyc(100);
    chk({oe_n, clk_en}, 32'h0);
    cyc(4100);
    chk(32'(int_rst), 0);
    rd_chk(OFF_CAUSE, 32'h40, RESP_OKAY);
    // interrupt latch and hold
    irq <= 8'h06;
    istart <= 1'b1;
    @(posedge clk);
    istart <= 1'b0;
    irq <= 8'h01;
    cyc(2);
    chk({ivalid, isel}, 32'h9);
    istart <= 1'b1;
    @(posedge clk);
    istart <= 1'b0;
    cyc(2);
    chk({ivalid, isel}, 32'h9);
    idone <= 1'b1;
    @(posedge clk);
    idone <= 1'b0;
    cyc(2);
    chk(32'(ivalid), 0);
    irq <= 8'h00;
    mon <= 1'b1;
    cyc(5);
    chk(32'(vec), 32'(VEC_MON));
    mon <= 1'b0;
    cyc(5);
    chk(32'(vec), 32'(VEC_USER));
    ev(0, 32'h08);
    ev(1, 32'h08);
    ev(2, 32'h10);
    ev(3, 32'h00);
    ev(4, 32'h20);
    chk({fmon, vec}, {15'h0, 1'b1, VEC_MON});
    // one full prescaler turn advances the watchdog once
    cyc(8200);
    rd_mask = 32'h0000_FF00;
    rd_chk(OFF_STATUS, 32'h0000_0100, RESP_OKAY);
    // high-voltage detect in monitor mode clears it
    mon <= 1'b1;
    hvi <= 1'b1;
    cyc(5);
    rd_chk(OFF_STATUS, 32'h0000_0000, RESP_OKAY);
    rd_mask = 32'hFFFF_FFFF;
    mon <= 1'b0;
    hvi <= 1'b0;
    // power-up pulse: long sequence, flags back to power-up only, forced monitor cleared
    pu <= 1'b1;
    cyc(3);
    pu <= 1'b0;
    cyc(100);
    chk({oe_n, clk_en, int_rst}, 32'h1);
    cyc(4100);
    chk(32'(int_rst), 0);
    rd_chk(OFF_CAUSE, 32'h1, RESP_OKAY);
    chk({fmon, vec}, 32'(VEC_USER));
    give_verdict();
  end
endmodule
`default_nettype wire
